//--- verilog/adlp_top.sv
`timescale 1ns/1ns
`include "adlp_map.svh"
module adlp_top (
  input wire logic i_mclk,               // 10 MHz clock
  input wire logic i_rst_n,              // sync reset, active low
  input wire logic i_vbat_ok,            // battery above 2.5V comparator
  input wire logic i_vbus_ok,            // bus supply comparator
  input wire logic i_io_supply,          // io supply present
  input wire logic i_ovp_cmp,            // above overvoltage threshold
  input wire logic i_uvlo_cmp,           // above undervoltage lockout level
  input wire logic i_ocp_cmp,            // current above selected trip level
  input wire logic i_id_attach_cmp,      // ID comparator: something attached
  input wire logic i_id_match_cmp,       // reference reached ID voltage
  input wire logic i_noncompliant_chg,   // charger classified non-compliant
  input wire logic [3:0] i_ocp_level,    // host overcurrent trip setting
  input wire logic i_alt_accessory_table_mode, // alternate table select
  input wire logic i_manual_en,          // host route override enable
  input wire logic [1:0] i_manual_route, // host route when manual
  input wire logic i_manual_mic_dp,      // host mic to data line
  input wire logic i_id_bypass_en,       // host bypass switch enable
  input wire logic i_flag_clr,           // host clear of all flags
  output logic o_powered,                // device powered
  output logic o_supply_from_bus,        // running from bus supply
  output logic o_i2c_en,                 // I2C interface enabled
  output logic o_load_sw_on,             // load switch gate
  output logic [3:0] o_ocp_trip_threshold, // level to comparator
  output logic o_id_isrc_en,             // ID current source
  output logic [4:0] o_id_ref,           // reference ramp value
  output logic [4:0] o_adc_result,       // latched ID code
  output logic o_adc_valid,              // result valid
  output logic o_alt_table_sel,          // decode table in use
  output logic o_sw_usb,                 // data lines to USB
  output logic o_sw_uart,                // data lines to UART
  output logic o_sw_audio,               // data lines to audio
  output logic o_mic_to_vbus,            // microphone_line to bus
  output logic o_mic_to_dp,              // microphone_line to data line
  output logic o_id_bypass_output,       // ID bypass switch
  output logic o_overvoltage_irq_flag,   // sticky ovp flag
  output logic o_protection_cleared_irq_flag, // sticky cleared flag
  output logic o_irq_n                   // host interrupt, active low
);
  adlp_sup_if sup ();
  adlp_pkg::adlp_det_e state_r;          // detection state
  logic [4:0] ref_r;                     // reference ramp
  logic [3:0] settle_r;                  // per-step settle count
  logic [4:0] adc_r;                     // latched result
  logic adc_valid_r;                     // result valid
  logic vbat_s;                          // synced battery ok
  logic vbus_s;                          // synced bus ok
  logic io_s;                            // synced io supply
  logic ovp_s;                           // synced ovp
  logic uvlo_s;                          // synced uvlo
  logic ocp_s;                           // synced ocp
  logic att_s;                           // synced id attach
  logic match_s;                         // synced ref match
  logic nc_s;                            // synced noncompliant
  logic ovp_flag_r;                      // sticky flag
  logic clr_flag_r;                      // sticky flag
  logic powered;                         // supply present
  logic det_req;                         // conversion wanted
  adlp_pkg::adlp_route_e route;          // chosen route
  logic [8:0] raw_in;
  logic [8:0] syn_out;

  assign raw_in = {i_vbat_ok, i_vbus_ok, i_io_supply, i_ovp_cmp, i_uvlo_cmp,
                   i_ocp_cmp, i_id_attach_cmp, i_id_match_cmp, i_noncompliant_chg};
  // every analog indication passes the three-flop filter
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1)
    begin : g_sync
      adlp_sync3 u_sync (
        .i_mclk (i_mclk),
        .i_rst_n (i_rst_n),
        .i_d (raw_in[g]),
        .o_q (syn_out[g])
      );
    end
  endgenerate
  assign {vbat_s, vbus_s, io_s, ovp_s, uvlo_s, ocp_s, att_s, match_s, nc_s} = syn_out;

  // supply supervision
  assign powered = vbat_s || vbus_s;
  assign o_powered = powered;
  assign o_supply_from_bus = !vbat_s && vbus_s;
  assign o_i2c_en = io_s && powered;

  // protection block hookup
  assign sup.vbus_ok = vbus_s && powered;
  // state sees only the filtered level: a raw pin into flops risks metastability
  assign sup.ovp = ovp_s;
  assign sup.uvlo_ok = uvlo_s;
  assign sup.ocp = ocp_s;
  adlp_prot u_prot (
    .i_mclk (i_mclk),
    .i_rst_n (i_rst_n),
    .sup (sup)
  );
  // raw pin gates the switch directly so turn-off stays under one microsecond
  assign o_load_sw_on = sup.sw_on && !i_ovp_cmp;
  // comparator level follows host setting directly
  assign o_ocp_trip_threshold = i_ocp_level;

  // conversion request: bus low with attach, or bus high odd charger
  assign det_req = att_s && (!vbus_s || nc_s);

  // detection state machine
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      state_r <= adlp_pkg::ST_STANDBY;
    else if (!powered)
      state_r <= adlp_pkg::ST_OFF;
    else
    begin
      case (state_r)
        adlp_pkg::ST_OFF:
          state_r <= adlp_pkg::ST_STANDBY;
        adlp_pkg::ST_STANDBY:
          if (det_req)
            state_r <= adlp_pkg::ST_CONV;
        adlp_pkg::ST_CONV:
          if (!att_s)
            state_r <= adlp_pkg::ST_STANDBY;
          else if (settle_r == `ADLP_ADC_SETTLE_CYC && (match_s || ref_r == `ADLP_ADC_MAX))
            state_r <= adlp_pkg::ST_ATTACHED;
        adlp_pkg::ST_ATTACHED:
          if (!att_s)
            state_r <= adlp_pkg::ST_STANDBY;
        default:
          state_r <= adlp_pkg::ST_STANDBY;
      endcase
    end
  end

  // reference ramp: settle, then compare, then step
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || state_r != adlp_pkg::ST_CONV)
    begin
      ref_r <= 5'h00;
      settle_r <= 4'h0;
    end
    else if (settle_r != `ADLP_ADC_SETTLE_CYC)
      settle_r <= settle_r + 4'h1;
    else if (!match_s && ref_r != `ADLP_ADC_MAX)
    begin
      ref_r <= ref_r + 5'h01;
      settle_r <= 4'h0;
    end
  end

  // result latch; valid flag cleared on detach, code held
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      adc_r <= `ADLP_ADC_RST;
      adc_valid_r <= 1'b0;
    end
    else if (state_r == adlp_pkg::ST_CONV && settle_r == `ADLP_ADC_SETTLE_CYC
             && att_s && (match_s || ref_r == `ADLP_ADC_MAX))
    begin
      adc_r <= ref_r;
      adc_valid_r <= 1'b1;
    end
    else if (state_r != adlp_pkg::ST_ATTACHED && state_r != adlp_pkg::ST_CONV)
      adc_valid_r <= 1'b0;
  end
  assign o_adc_result = adc_r;
  assign o_adc_valid = adc_valid_r;
  assign o_id_ref = ref_r;
  // source stays on after a match so detach is seen
  assign o_id_isrc_en = (state_r == adlp_pkg::ST_CONV) || (state_r == adlp_pkg::ST_ATTACHED);
  assign o_alt_table_sel = i_alt_accessory_table_mode;

  // route choice: host override, else coarse split by code
  always_comb
  begin
    route = adlp_pkg::RT_NONE;
    if (i_manual_en)
      route = adlp_pkg::adlp_route_e'(i_manual_route);
    else if (adc_valid_r && !i_alt_accessory_table_mode)
    begin
      if (adc_r >= 5'h17 && adc_r <= 5'h19)
        route = adlp_pkg::RT_USB;
      else if (adc_r == 5'h14 || adc_r == 5'h16 || adc_r == 5'h1C || adc_r == 5'h1D)
        route = adlp_pkg::RT_UART;
      else
        route = adlp_pkg::RT_AUDIO;
    end
    else if (adc_valid_r)
      route = (adc_r == 5'h16 || adc_r == 5'h17 || adc_r == 5'h1A)
              ? adlp_pkg::RT_NONE : adlp_pkg::RT_AUDIO;
  end

  // switch drive registered, one path at most
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_sw_usb <= 1'b0;
      o_sw_uart <= 1'b0;
      o_sw_audio <= 1'b0;
      o_mic_to_vbus <= 1'b0;
      o_mic_to_dp <= 1'b0;
      o_id_bypass_output <= 1'b0;
    end
    else
    begin
      o_sw_usb <= (route == adlp_pkg::RT_USB);
      o_sw_uart <= (route == adlp_pkg::RT_UART);
      o_sw_audio <= (route == adlp_pkg::RT_AUDIO);
      // mic sources exclusive; data line only on host request
      o_mic_to_dp <= i_manual_mic_dp;
      o_mic_to_vbus <= !i_manual_mic_dp && route == adlp_pkg::RT_AUDIO && !vbus_s;
      o_id_bypass_output <= i_id_bypass_en;
    end
  end

  // sticky flags, set wins over host clear
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      ovp_flag_r <= 1'b0;
      clr_flag_r <= 1'b0;
    end
    else
    begin
      ovp_flag_r <= sup.ovp_evt || (ovp_flag_r && !(i_flag_clr && o_i2c_en));
      clr_flag_r <= sup.clr_evt || (clr_flag_r && !(i_flag_clr && o_i2c_en));
    end
  end
  assign o_overvoltage_irq_flag = ovp_flag_r;
  assign o_protection_cleared_irq_flag = clr_flag_r;
  assign o_irq_n = !(ovp_flag_r || clr_flag_r);

  AST_RESET_STANDBY: assert property (@(posedge i_mclk)
    !i_rst_n |=> state_r == adlp_pkg::ST_STANDBY || state_r == adlp_pkg::ST_OFF)
    else $error("not standby after reset");
  AST_ATTACH_CONV: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_r == adlp_pkg::ST_STANDBY && det_req && powered) |=> state_r == adlp_pkg::ST_CONV)
    else $error("attach missed");
  AST_FLAG_STICKY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (ovp_flag_r && !i_flag_clr) |=> ovp_flag_r) else $error("flag dropped");
  AST_SET_WINS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sup.clr_evt |=> clr_flag_r && !o_irq_n) else $error("cleared event lost");
  AST_ONE_PATH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $onehot0({o_sw_usb, o_sw_uart, o_sw_audio})) else $error("two paths on");
  AST_MIC_EXCL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !(o_mic_to_vbus && o_mic_to_dp)) else $error("mic on both");
  AST_I2C_GATE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !io_s |-> !o_i2c_en) else $error("i2c without io supply");
  AST_LATCH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_r == adlp_pkg::ST_CONV ##1 state_r == adlp_pkg::ST_ATTACHED)
    |-> adc_valid_r && adc_r == $past(ref_r)) else $error("bad latch");
  AST_ISRC_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_r == adlp_pkg::ST_ATTACHED |-> o_id_isrc_en) else $error("source off");
  // fast path: the pin itself must hold the switch off, filter or not
  AST_OVP_FAST: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_ovp_cmp |-> !o_load_sw_on) else $error("switch on with overvoltage pin high");
  COV_CONV: cover property (@(posedge i_mclk) state_r == adlp_pkg::ST_CONV ##[1:300] state_r == adlp_pkg::ST_ATTACHED);
  COV_DETACH: cover property (@(posedge i_mclk) state_r == adlp_pkg::ST_ATTACHED ##1 state_r == adlp_pkg::ST_STANDBY);
  COV_IRQ: cover property (@(posedge i_mclk) $fell(o_irq_n));
endmodule

//--- verilog/adlp_map.svh
`ifndef ADLP_MAP_SVH
`define ADLP_MAP_SVH
// timing figures as printed, counts derived at 10 MHz
`define ADLP_CLK_NS 100
`define ADLP_OVP_TOFF_NS 1000
// longest time: round down, at least one cycle
`define ADLP_OVP_TOFF_CYC ((`ADLP_OVP_TOFF_NS / `ADLP_CLK_NS) < 1 ? 1 : (`ADLP_OVP_TOFF_NS / `ADLP_CLK_NS))
`define ADLP_OCP_TIMEOUT_CYC 16'h0400
`define ADLP_OVP_DEGLITCH_CYC 16'h0800
`define ADLP_ADC_SETTLE_CYC 4'h4
`define ADLP_ADC_MAX 5'h1F
`define ADLP_ADC_RST 5'h1F
`define ADLP_OCP_LVL_RST 4'h8
`define ADLP_PATH_USB 2'h1
`define ADLP_PATH_UART 2'h2
`define ADLP_PATH_AUDIO 2'h3
`endif

//--- verilog/adlp_pkg.sv
package adlp_pkg;
  // top-level detection states
  typedef enum logic [2:0] {ST_OFF, ST_STANDBY, ST_CONV, ST_ATTACHED} adlp_det_e;
  // data-line route selection
  typedef enum logic [1:0] {RT_NONE, RT_USB, RT_UART, RT_AUDIO} adlp_route_e;
endpackage

//--- verilog/adlp_sup_if.sv
`timescale 1ns/1ns
// supply status shared between top and protection
interface adlp_sup_if;
  logic vbus_ok;   // bus supply present, debounced
  logic ovp;       // overvoltage seen, synchronised
  logic uvlo_ok;   // above undervoltage lockout
  logic ocp;       // overcurrent above trip
  logic sw_on;     // load switch drive
  logic ovp_evt;   // overvoltage entered pulse
  logic clr_evt;   // protection cleared pulse
  modport top (output vbus_ok, ovp, uvlo_ok, ocp, input sw_on, ovp_evt, clr_evt);
  modport prot (input vbus_ok, ovp, uvlo_ok, ocp, output sw_on, ovp_evt, clr_evt);
endinterface

//--- verilog/adlp_sync3.sv
`timescale 1ns/1ns
// three-stage synchroniser with agreement filter
module adlp_sync3 (
  input wire logic i_mclk,    // clock
  input wire logic i_rst_n,   // sync reset
  input wire logic i_d,       // async level
  output logic o_q            // filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // first stage only feeds the second
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // change counts once stages two and three agree
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_q <= 1'b0;
    else if (s2_r == s3_r)
      o_q <= s3_r;
  end
endmodule

//--- verilog/adlp_prot.sv
`timescale 1ns/1ns
`include "adlp_map.svh"
// load switch supervisor: ovp with uvlo-gated return, timed overcurrent trip
module adlp_prot (
  input wire logic i_mclk,     // clock
  input wire logic i_rst_n,    // sync reset
  adlp_sup_if.prot sup         // supply status and switch drive
);
  logic [15:0] ocp_cnt_r;      // overcurrent time-out counter
  logic [15:0] deg_cnt_r;      // re-enable deglitch counter
  logic ovp_lat_r;             // overvoltage episode active
  logic ocp_trip_r;            // overcurrent trip latched
  logic deg_done;
  assign deg_done = (deg_cnt_r == `ADLP_OVP_DEGLITCH_CYC);

  // overvoltage episode tracking and deglitch
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      ovp_lat_r <= 1'b0;
      deg_cnt_r <= 16'h0000;
    end
    else if (sup.ovp)
    begin
      ovp_lat_r <= 1'b1;
      deg_cnt_r <= 16'h0000;
    end
    else if (ovp_lat_r && sup.uvlo_ok)
    begin
      // restart on any dip so supply is stable when counted out
      if (deg_done)
        ovp_lat_r <= 1'b0;
      else
        deg_cnt_r <= deg_cnt_r + 16'h0001;
    end
    else
      deg_cnt_r <= 16'h0000;
  end

  // overcurrent time-out and trip
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || !sup.vbus_ok)
    begin
      ocp_cnt_r <= 16'h0000;
      ocp_trip_r <= 1'b0;
    end
    else if (!sup.ocp)
      ocp_cnt_r <= 16'h0000;
    else if (ocp_cnt_r == `ADLP_OCP_TIMEOUT_CYC)
      ocp_trip_r <= 1'b1;
    else
      ocp_cnt_r <= ocp_cnt_r + 16'h0001;
  end

  // switch off combinationally on ovp: well inside turn-off time
  assign sup.sw_on = sup.vbus_ok && !sup.ovp && !ovp_lat_r && !ocp_trip_r;
  assign sup.ovp_evt = sup.ovp && !ovp_lat_r;
  assign sup.clr_evt = ovp_lat_r && !sup.ovp && sup.uvlo_ok && deg_done;

  AST_OVP_OFF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sup.ovp |-> !sup.sw_on) else $error("switch on during overvoltage");
  AST_OVP_FLAG: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (sup.ovp && !ovp_lat_r) |-> sup.ovp_evt) else $error("no ovp event");
  AST_OCP_TRIP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (ocp_cnt_r == `ADLP_OCP_TIMEOUT_CYC && sup.ocp && sup.vbus_ok) |=> !sup.sw_on)
    else $error("no overcurrent trip");
  AST_OCP_START: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (sup.ocp && sup.vbus_ok && !ocp_trip_r && ocp_cnt_r == 16'h0000) |=> ocp_cnt_r == 16'h0001)
    else $error("time-out not started");
  AST_REEN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (sup.clr_evt && sup.vbus_ok && !ocp_trip_r) |=> (sup.sw_on || sup.ovp || !sup.vbus_ok || ocp_trip_r))
    else $error("switch not restored");
  // deglitch outlasts any short range, so cover the episode end itself
  COV_OVP: cover property (@(posedge i_mclk) $fell(ovp_lat_r));
  COV_OCP: cover property (@(posedge i_mclk) $fell(sup.sw_on) && ocp_trip_r);
endmodule

//--- sim/adlp_fe_model.sv
`timescale 1ns/1ns
// accessory and analog front end on the far side of the block
module adlp_fe_model (
  input wire logic i_attached,                 // accessory plugged in
  input wire logic [4:0] i_id_code,            // ramp step where id voltage sits
  input wire logic [3:0] i_load,               // current drawn, in trip steps
  input wire logic i_id_isrc_en,               // id current source
  input wire logic [4:0] i_id_ref,             // reference ramp
  input wire logic [3:0] i_ocp_trip_threshold, // trip level
  input wire logic i_load_sw_on,               // load switch gate
  output logic o_id_attach_cmp,                // id pulled down by a resistor
  output logic o_id_match_cmp,                 // reference reached id voltage
  output logic o_ocp_cmp                       // current above trip level
);
  // id comparators: no source current means no id voltage to match
  assign o_id_attach_cmp = i_attached;
  assign o_id_match_cmp = i_attached & i_id_isrc_en & (i_id_ref >= i_id_code);
  // no current flows through an open switch
  assign o_ocp_cmp = i_load_sw_on & (i_load > i_ocp_trip_threshold);
endmodule

//--- sim/tb_adlp_top.sv
`timescale 1ns/1ns
`include "adlp_map.svh"
// self-checking bench for the detect and load protect block
module tb_adlp_top;
  localparam int DEG = `ADLP_OVP_DEGLITCH_CYC; // re-enable deglitch
  localparam int OCT = `ADLP_OCP_TIMEOUT_CYC; // overcurrent time-out
  logic i_mclk, i_rst_n, i_vbat_ok, i_vbus_ok, i_io_supply, i_ovp_cmp, i_uvlo_cmp;
  logic i_ocp_cmp, i_id_attach_cmp, i_id_match_cmp, i_noncompliant_chg, i_flag_clr;
  logic i_alt_accessory_table_mode, i_manual_en, i_manual_mic_dp, i_id_bypass_en;
  logic [3:0] i_ocp_level;
  logic [1:0] i_manual_route;
  logic o_powered, o_supply_from_bus, o_i2c_en, o_load_sw_on, o_id_isrc_en, o_adc_valid;
  logic o_alt_table_sel, o_sw_usb, o_sw_uart, o_sw_audio, o_mic_to_vbus, o_mic_to_dp;
  logic o_id_bypass_output, o_overvoltage_irq_flag, o_protection_cleared_irq_flag, o_irq_n;
  logic [3:0] o_ocp_trip_threshold;
  logic [4:0] o_id_ref, o_adc_result;
  logic acc_in; // accessory plugged
  logic [4:0] acc_code; // accessory id step
  logic [3:0] load; // load current
  logic [2:0] sv [6] = '{3'b100, 3'b110, 3'b101, 3'b111, 3'b010, 3'b000}; // vbat, vbus, io
  int n_fail = 0;
  int tests_run = 0;
  int cyc_cnt = 0;

  adlp_top dut (
    .i_mclk, .i_rst_n, .i_vbat_ok, .i_vbus_ok, .i_io_supply, .i_ovp_cmp, .i_uvlo_cmp, .i_ocp_cmp,
    .i_id_attach_cmp, .i_id_match_cmp, .i_noncompliant_chg, .i_ocp_level, .i_alt_accessory_table_mode,
    .i_manual_en, .i_manual_route, .i_manual_mic_dp, .i_id_bypass_en, .i_flag_clr, .o_powered,
    .o_supply_from_bus, .o_i2c_en, .o_load_sw_on, .o_ocp_trip_threshold, .o_id_isrc_en, .o_id_ref,
    .o_adc_result, .o_adc_valid, .o_alt_table_sel, .o_sw_usb, .o_sw_uart, .o_sw_audio, .o_mic_to_vbus,
    .o_mic_to_dp, .o_id_bypass_output, .o_overvoltage_irq_flag, .o_protection_cleared_irq_flag, .o_irq_n
  );

  adlp_fe_model fe (
    .i_attached(acc_in), .i_id_code(acc_code), .i_load(load), .i_id_isrc_en(o_id_isrc_en),
    .i_id_ref(o_id_ref), .i_ocp_trip_threshold(o_ocp_trip_threshold), .i_load_sw_on(o_load_sw_on),
    .o_id_attach_cmp(i_id_attach_cmp), .o_id_match_cmp(i_id_match_cmp), .o_ocp_cmp(i_ocp_cmp)
  );

  // 10 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // hang guard, well above the expected run length
  always @(posedge i_mclk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000)
    begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  // compare and count
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // wait n edges, then let outputs settle
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #10;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // supplies change together, filters need a few cycles
  task automatic sup(input logic [2:0] s);
    @(posedge i_mclk);
    {i_vbat_ok, i_vbus_ok, i_io_supply} <= s;
    tick(8);
  endtask

  // host flag clear held for four cycles
  task automatic clr();
    @(posedge i_mclk);
    i_flag_clr <= 1'b1;
    tick(3);
    @(posedge i_mclk);
    i_flag_clr <= 1'b0;
    tick(2);
  endtask

  // attach an accessory, await the code, check routing, then detach
  task automatic conv(input logic vb, nc, alt, input logic [4:0] code, input logic [2:0] rt, input logic microphone_line);
    int k;
    k = 0;
    @(posedge i_mclk);
    i_vbus_ok <= vb;
    i_noncompliant_chg <= nc;
    i_alt_accessory_table_mode <= alt;
    acc_code <= code;
    acc_in <= 1'b1;
    while (o_adc_valid !== 1'b1 && k < 600)
    begin
      tick(1);
      k = k + 1;
    end
    chk(5'(o_adc_valid), 5'h01);
    chk(o_adc_result, code);
    chk(5'(o_id_isrc_en), 5'h01);
    tick(3);
    chk(5'({o_sw_usb, o_sw_uart, o_sw_audio}), 5'(rt));
    chk(5'(o_mic_to_vbus), 5'(microphone_line));
    chk(5'(o_alt_table_sel), 5'(alt));
    @(posedge i_mclk);
    acc_in <= 1'b0;
    i_noncompliant_chg <= 1'b0;
    tick(40);
    chk(5'(o_adc_valid), 5'h00);
  endtask

  initial
  begin
    {i_rst_n, i_vbus_ok, i_ovp_cmp, i_noncompliant_chg, i_flag_clr, acc_in} = 6'h00;
    {i_vbat_ok, i_io_supply, i_uvlo_cmp} = 3'h7;
    {i_alt_accessory_table_mode, i_manual_en, i_manual_mic_dp, i_id_bypass_en} = 4'h0;
    i_manual_route = 2'h0;
    i_ocp_level = 4'h8;
    acc_code = 5'h00;
    load = 4'h0;
    tick(15);
    // values held in reset
    chk(o_adc_result, 5'h1F);
    chk(o_id_ref, 5'h00);
    chk(5'({o_irq_n, o_overvoltage_irq_flag, o_protection_cleared_irq_flag}), 5'h04);
    @(posedge i_mclk);
    i_rst_n <= 1'b1;
    tick(8);
    chk(5'(o_adc_valid), 5'h00);
    // supply state table
    foreach (sv[i])
    begin
      sup(sv[i]);
      chk(5'(o_powered), 5'(sv[i][2] | sv[i][1]));
      chk(5'(o_supply_from_bus), 5'(!sv[i][2] & sv[i][1]));
      chk(5'(o_i2c_en), 5'(sv[i][0]));
      chk(5'(o_load_sw_on), 5'(sv[i][1]));
    end
    sup(3'b111);
    // host trip level reaches the comparator
    for (int l = 0; l < 16; l += 5)
    begin
      @(posedge i_mclk);
      i_ocp_level <= 4'(l);
      tick(1);
      chk(5'(o_ocp_trip_threshold), 5'(l));
    end
    @(posedge i_mclk);
    i_ocp_level <= 4'h8;
    // overvoltage: fast off, flag, deglitched return
    @(posedge i_mclk);
    i_ovp_cmp <= 1'b1;
    #10;
    chk(5'(o_load_sw_on), 5'h00);
    tick(6);
    chk(5'({o_overvoltage_irq_flag, o_irq_n}), 5'h02);
    @(posedge i_mclk);
    i_ovp_cmp <= 1'b0;
    tick(DEG - 16);
    chk(5'(o_load_sw_on), 5'h00);
    tick(40);
    chk(5'(o_load_sw_on), 5'h01);
    chk(5'(o_protection_cleared_irq_flag), 5'h01);
    // clear ignored without io supply, taken with it
    sup(3'b110);
    clr();
    chk(5'({o_overvoltage_irq_flag, o_protection_cleared_irq_flag}), 5'h03);
    sup(3'b111);
    clr();
    chk(5'({o_overvoltage_irq_flag, o_protection_cleared_irq_flag, o_irq_n}), 5'h01);
    // overvoltage clears into undervoltage: stays off
    @(posedge i_mclk);
    i_ovp_cmp <= 1'b1;
    i_uvlo_cmp <= 1'b0;
    tick(8);
    @(posedge i_mclk);
    i_ovp_cmp <= 1'b0;
    tick(DEG + 40);
    chk(5'(o_load_sw_on), 5'h00);
    @(posedge i_mclk);
    i_uvlo_cmp <= 1'b1;
    tick(DEG + 40);
    chk(5'(o_load_sw_on), 5'h01);
    clr();
    // overcurrent: short excess forgiven, long excess trips
    @(posedge i_mclk);
    load <= 4'h9;
    tick(OCT - 20);
    chk(5'(o_load_sw_on), 5'h01);
    @(posedge i_mclk);
    i_ocp_level <= 4'hA;
    tick(OCT);
    chk(5'(o_load_sw_on), 5'h01);
    @(posedge i_mclk);
    i_ocp_level <= 4'h8;
    tick(OCT + 20);
    chk(5'(o_load_sw_on), 5'h00);
    @(posedge i_mclk);
    load <= 4'h0;
    i_vbus_ok <= 1'b0;
    tick(8);
    sup(3'b111);
    chk(5'(o_load_sw_on), 5'h01);
    // id conversions across routes, tables and the top code
    conv(1'b0, 1'b0, 1'b0, 5'h17, 3'b100, 1'b0);
    conv(1'b0, 1'b0, 1'b0, 5'h14, 3'b010, 1'b0);
    conv(1'b0, 1'b0, 1'b0, 5'h05, 3'b001, 1'b1);
    conv(1'b0, 1'b0, 1'b0, 5'h1F, 3'b001, 1'b1);
    conv(1'b0, 1'b0, 1'b1, 5'h16, 3'b000, 1'b0);
    conv(1'b0, 1'b0, 1'b1, 5'h05, 3'b001, 1'b1);
    // bus present with a compliant attachment: no conversion
    @(posedge i_mclk);
    i_vbus_ok <= 1'b1;
    i_alt_accessory_table_mode <= 1'b0;
    acc_in <= 1'b1;
    tick(400);
    chk(5'(o_adc_valid), 5'h00);
    @(posedge i_mclk);
    acc_in <= 1'b0;
    tick(20);
    conv(1'b1, 1'b1, 1'b0, 5'h1C, 3'b010, 1'b0);
    // host routing, microphone and bypass control
    @(posedge i_mclk);
    i_manual_en <= 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      @(posedge i_mclk);
      i_manual_route <= 2'(r);
      tick(3);
      chk(5'({o_sw_usb, o_sw_uart, o_sw_audio}), (r == 0) ? 5'h00 : 5'(3'h4 >> (r - 1)));
    end
    @(posedge i_mclk);
    i_manual_mic_dp <= 1'b1;
    i_id_bypass_en <= 1'b1;
    tick(3);
    chk(5'({o_mic_to_dp, o_mic_to_vbus, o_id_bypass_output}), 5'h05);
    @(posedge i_mclk);
    {i_manual_mic_dp, i_id_bypass_en, i_manual_en} <= 3'h0;
    tick(3);
    chk(5'({o_mic_to_dp, o_id_bypass_output}), 5'h00);
    conclude();
  end
endmodule
